// ===== common/ladder_ref_pkg.sv
package ladder_ref_pkg;

  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [1:0] CTRL_OFF = 2'h0;
  localparam logic [1:0] LEVEL_OFF = 2'h1;
  localparam logic [1:0] SWITCH_OFF = 2'h2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  localparam int POWER_BIT = 7;
  localparam int PIN_BIT = 6;
  localparam int RANGE_BIT = 5;
  localparam int SOURCE_BIT = 4;
  localparam int TAP_MSB = 3;
  localparam int TAP_LSB = 0;
  localparam int TAP_W = 4;
  localparam int TAP_COUNT = 16;

  // Output level in units of span/96, so both ranges are exact integers
  localparam int LEVEL_W = 7;
  localparam logic [6:0] LEVEL_OFF_CODE = 7'h00;
  localparam logic [6:0] LOW_STEP = 7'h04;
  localparam logic [6:0] HIGH_STEP = 7'h03;
  localparam logic [6:0] HIGH_BASE = 7'h18;

  localparam int CLK_PERIOD_PS = 5000;
  localparam int BREAK_NS = 10;
  localparam int BREAK_CYC = (BREAK_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
  localparam int BREAK_W = 2;
  localparam int SETTLE_W = 8;

  typedef enum logic [1:0] {SW_OPEN, SW_RAILS, SW_EXT} switch_state_t;

  function automatic logic addr_hit(input logic [1:0] addr,
                                    input logic [1:0] off);
    return addr == off;
  endfunction

  function automatic logic [6:0] level_code(input logic range_low,
                                            input logic [3:0] tap);
    logic [6:0] t;
    t = {3'h0, tap};
    if (range_low) begin
      return 7'(LOW_STEP * t);
    end
    return 7'(HIGH_BASE + HIGH_STEP * t);
  endfunction

endpackage

// ===== logic/ladder_ref_regs.sv
`timescale 1ns/10ps
module ladder_ref_regs
  import ladder_ref_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] level_i,
  input wire logic [7:0] switch_i,
  output logic [7:0] ctrl_o,
  output logic [7:0] reg_rdata_o
);

  logic [7:0] ctrl_reg;
  logic [7:0] rdata_reg;
  wire ctrl_wr = clk_en_i & reg_wr_i & addr_hit(reg_addr_i, CTRL_OFF);
  wire hit_ctrl = addr_hit(reg_addr_i, CTRL_OFF);
  wire hit_level = addr_hit(reg_addr_i, LEVEL_OFF);
  wire hit_switch = addr_hit(reg_addr_i, SWITCH_OFF);
  wire [7:0] rd_mux = hit_ctrl ? ctrl_reg :
                      hit_level ? {1'b0, level_i} :
                      hit_switch ? switch_i : READ_IDLE;

  // Only a bus write or a reset moves the control bits, so sleep and
  // wake leave them alone
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= READ_IDLE;
    end else if (clk_en_i) begin
      rdata_reg <= reg_rd_i ? rd_mux : READ_IDLE;
    end
  end

  assign ctrl_o = ctrl_reg;
  assign reg_rdata_o = rdata_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  ctrl_write_lands_a: assert property (
    ctrl_wr |=> ctrl_reg == $past(reg_wdata_i))
    else $error("control write not stored");
  ctrl_held_a: assert property (
    !ctrl_wr |=> $stable(ctrl_reg))
    else $error("control register changed without a write");
  reset_clear_a: assert property (
    $rose(rst_b_i) |-> ctrl_reg == CTRL_RESET)
    else $error("control register not clear after reset");
  read_back_a: assert property (
    clk_en_i && reg_rd_i && hit_ctrl && !reg_wr_i
      |=> reg_rdata_o == $past(ctrl_reg))
    else $error("control readback wrong");

endmodule

// ===== logic/ladder_tap_decode.sv
`timescale 1ns/10ps
module ladder_tap_decode
  import ladder_ref_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic power_i,
  input wire logic range_low_i,
  input wire logic [3:0] tap_i,
  output logic [15:0] tap_sel_o,
  output logic [6:0] level_o
);

  logic [15:0] tap_sel_reg;
  logic [6:0] level_reg;
  wire [15:0] tap_onehot = 16'h0001 << tap_i;
  wire [15:0] tap_sel_next = power_i ? tap_onehot : 16'h0000;
  wire [6:0] level_next = power_i ? level_code(range_low_i, tap_i)
                                  : LEVEL_OFF_CODE;

  // A powered-down ladder closes no tap, so the mux cannot leak
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tap_sel_reg <= 16'h0000;
      level_reg <= LEVEL_OFF_CODE;
    end else if (clk_en_i) begin
      tap_sel_reg <= tap_sel_next;
      level_reg <= level_next;
    end
  end

  assign tap_sel_o = tap_sel_reg;
  assign level_o = level_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  tap_onehot_a: assert property (
    clk_en_i && power_i |=> $onehot(tap_sel_o)
      && tap_sel_o[$past(tap_i)])
    else $error("tap select not one-hot on coded tap");
  low_range_a: assert property (
    clk_en_i && power_i && range_low_i
      |=> level_o == 7'(4 * $past(tap_i)))
    else $error("low range level wrong");
  high_range_a: assert property (
    clk_en_i && power_i && !range_low_i
      |=> level_o == 7'(24 + 3 * $past(tap_i)))
    else $error("high range level wrong");
  off_no_tap_a: assert property (
    clk_en_i && !power_i |=> tap_sel_o == 16'h0000 && level_o == 7'h00)
    else $error("tap closed while powered down");

endmodule

// ===== logic/ladder_reference_control.sv
`timescale 1ns/10ps
module ladder_reference_control
  import ladder_ref_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic ref_power_on_o,
  output logic ref_pin_drive_o,
  output logic ref_range_low_o,
  output logic src_rails_o,
  output logic src_ext_o,
  output logic [15:0] tap_sel_o,
  output logic [6:0] ref_output_level_o,
  output logic ref_settling_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Control register and field split

  logic [7:0] ctrl;
  logic [7:0] switch_status;
  wire power_bit = ctrl[POWER_BIT];
  wire pin_bit = ctrl[PIN_BIT];
  wire range_bit = ctrl[RANGE_BIT];
  wire source_bit = ctrl[SOURCE_BIT];
  wire [3:0] ref_tap_code = ctrl[TAP_MSB:TAP_LSB];

  ladder_ref_regs u_regs (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .level_i(ref_output_level_o),
    .switch_i(switch_status),
    .ctrl_o(ctrl),
    .reg_rdata_o(reg_rdata_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Tap and level decode

  ladder_tap_decode u_decode (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .power_i(power_bit),
    .range_low_i(range_bit),
    .tap_i(ref_tap_code),
    .tap_sel_o(tap_sel_o),
    .level_o(ref_output_level_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Direct controls to the analog side

  logic power_reg;
  logic pin_reg;
  logic range_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_reg <= 1'b0;
      pin_reg <= 1'b0;
      range_reg <= 1'b0;
    end else if (clk_en_i) begin
      power_reg <= power_bit;
      pin_reg <= pin_bit;
      range_reg <= range_bit;
    end
  end

  assign ref_power_on_o = power_reg;
  assign ref_pin_drive_o = pin_reg;
  assign ref_range_low_o = range_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Supply source switches
  // The two supply pairs must never be shorted together through the
  // ladder, so a change of source opens both switches for a short gap
  // before the new pair closes. Powering down opens both, which cuts
  // all ladder current.

  switch_state_t state_reg;
  switch_state_t state_next;
  switch_state_t target;
  logic [1:0] break_cnt_reg;
  logic [1:0] break_cnt_next;
  logic rails_reg;
  logic ext_reg;

  wire switch_state_t src_pick = source_bit ? SW_EXT : SW_RAILS;
  assign target = power_bit ? src_pick : SW_OPEN;
  wire break_done = break_cnt_reg == 2'h0;

  always_comb begin
    state_next = state_reg;
    break_cnt_next = break_done ? 2'h0 : 2'(break_cnt_reg - 2'h1);
    case (state_reg)
      SW_OPEN: begin
        if (break_done && target != SW_OPEN) begin
          state_next = target;
        end
      end
      SW_RAILS, SW_EXT: begin
        if (target != state_reg) begin
          state_next = SW_OPEN;
          break_cnt_next = 2'(BREAK_CYC - 1);
        end
      end
      default: begin
        state_next = SW_OPEN;
        break_cnt_next = 2'(BREAK_CYC - 1);
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= SW_OPEN;
      break_cnt_reg <= 2'h0;
      rails_reg <= 1'b0;
      ext_reg <= 1'b0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      break_cnt_reg <= break_cnt_next;
      rails_reg <= state_next == SW_RAILS;
      ext_reg <= state_next == SW_EXT;
    end
  end

  assign src_rails_o = rails_reg;
  assign src_ext_o = ext_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Settling indication
  // The ladder output needs time to settle after any change of code,
  // range or source. This flag only counts a fixed time; it does not
  // watch the analog node, so a slow reference still needs margin.

  logic [7:0] ctrl_seen_reg;
  logic [7:0] settle_cnt_reg;
  logic settling_reg;

  wire ctrl_moved = ctrl != ctrl_seen_reg;
  wire switch_moved = state_next != state_reg;
  wire settle_start = ctrl_moved | switch_moved;
  wire settle_idle = settle_cnt_reg == 8'h00;
  wire [7:0] settle_cnt_next = settle_start ? 8'(SETTLE_CYC) :
                               settle_idle ? 8'h00 :
                               8'(settle_cnt_reg - 8'h01);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_seen_reg <= CTRL_RESET;
      settle_cnt_reg <= 8'h00;
      settling_reg <= 1'b0;
    end else if (clk_en_i) begin
      ctrl_seen_reg <= ctrl;
      settle_cnt_reg <= settle_cnt_next;
      settling_reg <= settle_cnt_next != 8'h00;
    end
  end

  assign ref_settling_o = settling_reg;
  assign switch_status = {4'h0, settling_reg, ext_reg, rails_reg,
                          power_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  wire rd_take = clk_en_i && reg_rd_i;
  wire rd_unmapped = !addr_hit(reg_addr_i, CTRL_OFF)
                     && !addr_hit(reg_addr_i, LEVEL_OFF)
                     && !addr_hit(reg_addr_i, SWITCH_OFF);

  sequence rails_open_s;
    $fell(src_rails_o);
  endsequence

  sequence ext_open_s;
    $fell(src_ext_o);
  endsequence

  sequence held_gap_s;
    (!src_rails_o && !src_ext_o) [*2];
  endsequence

  sequence ext_request_s;
    (clk_en_i && power_bit && source_bit) [*5];
  endsequence

  sequence rails_request_s;
    (clk_en_i && power_bit && !source_bit) [*5];
  endsequence

  property gap_after(s);
    s |-> held_gap_s;
  endproperty

  sequence level_read_s;
    rd_take && addr_hit(reg_addr_i, LEVEL_OFF);
  endsequence

  sequence switch_read_s;
    rd_take && addr_hit(reg_addr_i, SWITCH_OFF);
  endsequence

  sequence settle_hold_s;
    ref_settling_o [*8];
  endsequence

  sequence power_drop_s;
    clk_en_i && !power_bit && ref_power_on_o;
  endsequence

  power_follow_a: assert property (
    clk_en_i && power_bit != ref_power_on_o
      |=> ref_power_on_o == $past(power_bit))
    else $error("power control did not follow bit");
  pin_follow_a: assert property (
    clk_en_i |=> ref_pin_drive_o == $past(pin_bit))
    else $error("pin switch did not follow bit");
  range_follow_a: assert property (
    clk_en_i |=> ref_range_low_o == $past(range_bit))
    else $error("range output did not follow bit");
  no_short_a: assert property (
    !(src_rails_o && src_ext_o))
    else $error("both supply pairs closed");
  rails_gap_a: assert property (
    gap_after(rails_open_s))
    else $error("rails reopened without a gap");
  ext_gap_a: assert property (
    gap_after(ext_open_s))
    else $error("external pins reopened without a gap");
  ext_reach_a: assert property (
    ext_request_s |-> src_ext_o && !src_rails_o)
    else $error("external pins not selected");
  rails_reach_a: assert property (
    rails_request_s |-> src_rails_o && !src_ext_o)
    else $error("supply rails not selected");
  off_open_a: assert property (
    (clk_en_i && !power_bit) [*2] |-> !src_rails_o && !src_ext_o)
    else $error("ladder supplied while powered down");
  reset_quiet_a: assert property (
    $rose(rst_b_i) |-> !ref_power_on_o && !ref_pin_drive_o
      && tap_sel_o == 16'h0000)
    else $error("reference active after reset");
  settle_start_a: assert property (
    clk_en_i && ctrl_moved |=> ref_settling_o)
    else $error("settling flag missed a change");
  freeze_a: assert property (
    !clk_en_i |=> $stable(state_reg) && $stable(ref_power_on_o)
      && $stable(settle_cnt_reg))
    else $error("state moved while clock enable low");
  freeze_out_a: assert property (
    !clk_en_i |=> $stable(reg_rdata_o) && $stable(tap_sel_o)
      && $stable(src_ext_o) && $stable(src_rails_o))
    else $error("outputs moved while clock enable low");
  level_read_a: assert property (
    level_read_s |=> reg_rdata_o == {1'b0, $past(ref_output_level_o)})
    else $error("level readback wrong");
  switch_read_a: assert property (
    switch_read_s |=> reg_rdata_o == {4'h0, $past(ref_settling_o),
      $past(src_ext_o), $past(src_rails_o), $past(ref_power_on_o)})
    else $error("switch status readback wrong");
  unmapped_read_a: assert property (
    rd_take && rd_unmapped |=> reg_rdata_o == READ_IDLE)
    else $error("unmapped read not idle");
  idle_read_a: assert property (
    clk_en_i && !reg_rd_i |=> reg_rdata_o == READ_IDLE)
    else $error("read data held past one cycle");
  supply_powered_a: assert property (
    src_rails_o || src_ext_o |-> ref_power_on_o)
    else $error("ladder supplied while power off");
  tap_off_a: assert property (
    !ref_power_on_o |-> tap_sel_o == 16'h0000
      && ref_output_level_o == LEVEL_OFF_CODE)
    else $error("tap or level active while power off");
  tap_single_a: assert property (
    ref_power_on_o |-> $onehot(tap_sel_o))
    else $error("powered ladder without exactly one tap");
  tap_code_a: assert property (
    clk_en_i && power_bit |=> tap_sel_o[$past(ref_tap_code)])
    else $error("tap select does not match the code");
  settle_hold_a: assert property (
    clk_en_i && settle_start |=> settle_hold_s)
    else $error("settling flag dropped early");
  settle_end_a: assert property (
    $fell(ref_settling_o) |-> $past(settle_cnt_reg) == 8'h01)
    else $error("settling flag ended before its count");
  power_drop_a: assert property (
    power_drop_s |=> !ref_power_on_o && !src_rails_o && !src_ext_o
      && tap_sel_o == 16'h0000)
    else $error("power down did not open the ladder");

endmodule

// ===== sim/ladder_reference_control_test.sv
`timescale 1ns/10ps
module ladder_reference_control_test
  import ladder_ref_pkg::*;
;
  logic clk_i;
  logic rst_b_i;
  logic clk_en_i;
  logic [1:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic ref_power_on_o;
  logic ref_pin_drive_o;
  logic ref_range_low_o;
  logic src_rails_o;
  logic src_ext_o;
  logic [15:0] tap_sel_o;
  logic [6:0] ref_output_level_o;
  logic ref_settling_o;
  int error_cnt;
  int tests_run;
  logic [7:0] rd_val;
  logic [6:0] exp_lvl;

  ladder_reference_control dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ref_power_on_o(ref_power_on_o), .ref_pin_drive_o(ref_pin_drive_o),
    .ref_range_low_o(ref_range_low_o), .src_rails_o(src_rails_o),
    .src_ext_o(src_ext_o), .tap_sel_o(tap_sel_o),
    .ref_output_level_o(ref_output_level_o),
    .ref_settling_o(ref_settling_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each access returns 1 ns after its sampling edge, so calls chain with
  // no idle cycle and no strobe is assigned twice in one time step
  task automatic bus_wr(input logic [1:0] addr, input logic [7:0] data);
    reg_addr_i <= addr;
    reg_wdata_i <= data;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic bus_rd(input logic [1:0] addr, output logic [7:0] data);
    reg_addr_i <= addr;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    data = reg_rdata_o;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk_all_off();
    chk({ref_power_on_o, ref_pin_drive_o, ref_range_low_o, src_rails_o,
         src_ext_o, ref_settling_o}, 16'h0000);
    chk(tap_sel_o, 16'h0000);
    chk(ref_output_level_o, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    end_of_test();
  end

  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst_b_i = 1'b0;
    clk_en_i = 1'b1;
    reg_addr_i = 2'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    #1;
    chk_all_off();
    bus_rd(CTRL_OFF, rd_val);
    chk(rd_val, 8'h00);
    bus_rd(SWITCH_OFF, rd_val);
    chk(rd_val, 8'h00);
    // Write then read with no gap; read data lasts one cycle only
    bus_wr(CTRL_OFF, 8'h9a);
    bus_rd(CTRL_OFF, rd_val);
    chk(rd_val, 8'h9a);
    cycles(1);
    chk(reg_rdata_o, 8'h00);
    chk(ref_power_on_o, 1'b1);
    chk(tap_sel_o, 16'h0400);
    chk(ref_output_level_o, 7'h36);
    // Every tap in both ranges, power on, supply rails
    for (int r = 0; r < 2; r++) begin
      for (int tap = 0; tap < TAP_COUNT; tap++) begin
        bus_wr(CTRL_OFF, {2'b10, r[0], 1'b0, tap[3:0]});
        cycles(1);
        exp_lvl = (r == 1) ? 7'(4 * tap) : 7'(24 + 3 * tap);
        chk(tap_sel_o, 16'h0001 << tap);
        chk(ref_output_level_o, exp_lvl);
        chk(ref_range_low_o, r[0]);
        bus_rd(LEVEL_OFF, rd_val);
        chk(rd_val, {1'b0, exp_lvl});
      end
    end
    // Break-before-make from supply rails to external pins
    bus_wr(CTRL_OFF, 8'h80);
    cycles(4);
    chk({src_rails_o, src_ext_o}, 2'b10);
    bus_wr(CTRL_OFF, 8'h90);
    cycles(1);
    chk({src_rails_o, src_ext_o, ref_settling_o}, 3'b001);
    cycles(1);
    chk({src_rails_o, src_ext_o}, 2'b00);
    cycles(1);
    chk({src_rails_o, src_ext_o}, 2'b01);
    bus_rd(SWITCH_OFF, rd_val);
    chk(rd_val, 8'h0d);
    cycles(100);
    chk(ref_settling_o, 1'b1);
    cycles(150);
    chk(ref_settling_o, 1'b0);
    bus_rd(SWITCH_OFF, rd_val);
    chk(rd_val, 8'h05);
    // Idle time leaves the control register alone
    bus_rd(CTRL_OFF, rd_val);
    chk(rd_val, 8'h90);
    // Power down drops the tap, level and both supply switches
    bus_wr(CTRL_OFF, 8'h1f);
    cycles(4);
    chk({ref_power_on_o, src_rails_o, src_ext_o}, 3'b000);
    chk(tap_sel_o, 16'h0000);
    chk(ref_output_level_o, 7'h00);
    // Pin drive works without power
    bus_wr(CTRL_OFF, 8'h40);
    cycles(1);
    chk({ref_pin_drive_o, ref_power_on_o}, 2'b10);
    bus_wr(CTRL_OFF, 8'h00);
    cycles(1);
    chk(ref_pin_drive_o, 1'b0);
    // Writes to status and unmapped places, and gated strobes, are dropped
    bus_wr(CTRL_OFF, 8'h40);
    bus_wr(LEVEL_OFF, 8'hff);
    bus_wr(SWITCH_OFF, 8'hff);
    bus_wr(2'h3, 8'hff);
    clk_en_i <= 1'b0;
    bus_wr(CTRL_OFF, 8'h55);
    clk_en_i <= 1'b1;
    bus_rd(CTRL_OFF, rd_val);
    chk(rd_val, 8'h40);
    bus_rd(2'h3, rd_val);
    chk(rd_val, 8'h00);
    // All bits writable, then a reset in mid-run clears everything
    bus_wr(CTRL_OFF, 8'hff);
    bus_rd(CTRL_OFF, rd_val);
    chk(rd_val, 8'hff);
    cycles(4);
    rst_b_i <= 1'b0;
    cycles(2);
    chk_all_off();
    rst_b_i <= 1'b1;
    #1;
    bus_rd(CTRL_OFF, rd_val);
    chk(rd_val, 8'h00);
    cycles(1);
    chk_all_off();
    end_of_test();
  end
endmodule
